/* File: rtc_defs.svh */
/*
  Constants for the user time register block: register offsets, field
  positions and masks, reset values and timing figures.
  Assumes it is included by bare name from every file that needs it.
*/
`ifndef RTC_DEFS_SVH
`define RTC_DEFS_SVH

// ==========================================================================
// Register offsets
`define ADDR_FRAC        8'h00
`define ADDR_SECONDS     8'h01
`define ADDR_MINUTES     8'h02
`define ADDR_HOURS       8'h03
`define ADDR_WEEKDAY     8'h04
`define ADDR_DAY         8'h05
`define ADDR_MONTH       8'h06
`define ADDR_YEAR        8'h07
`define ADDR_CONTROL     8'h08
`define ADDR_HALT        8'h0C
`define ADDR_FLAGS       8'h0F
`define ADDR_TAMPER1     8'h14
`define ADDR_TAMPER2     8'h15

// ==========================================================================
// Field positions
`define BIT_OSC_STOP     7
`define BIT_HALT         6
`define BIT_ARM          7
`define BIT_FLAG1        1
`define BIT_FLAG2        0
`define CENTURY_LSB      6
`define CENTURY_MSB      7

// ==========================================================================
// Time field masks, one per time register, plus a second hours mask with the century bits
`define MASK_FRAC        8'hFF
`define MASK_SECONDS     8'h7F
`define MASK_MINUTES     8'h7F
`define MASK_HOURS       8'h3F
`define MASK_HOURS_CENT  8'hFF
`define MASK_WEEKDAY     8'h07
`define MASK_DAY         8'h3F
`define MASK_MONTH       8'h1F
`define MASK_YEAR        8'hFF

// ==========================================================================
// Counter ranges in BCD
`define BCD_ZERO         8'h00
`define BCD_ONE          8'h01
`define BCD_NINE         4'h9
`define MAX_FRAC         8'h99
`define MAX_SIXTY        8'h59
`define MAX_HOURS        8'h23
`define MAX_WEEKDAY      8'h07
`define MAX_MONTH        8'h12
`define MAX_YEAR         8'h99
`define DAYS_31          8'h31
`define DAYS_30          8'h30
`define DAYS_29          8'h29
`define DAYS_28          8'h28
`define MONTH_FEB        8'h02
`define MONTH_APR        8'h04
`define MONTH_JUN        8'h06
`define MONTH_SEP        8'h09
`define MONTH_NOV        8'h11

// ==========================================================================
// Reset values and timing
`define RESET_BYTE       8'h00
`define RESET_ONE_BASED  8'h01
`define CLK_PERIOD_NS    100
`define FRAC_PERIOD_NS   10000000

`endif

/* File: rtc_pkg.sv */
/*
  Types shared by the user time register block.
  Assumes rtc_defs.svh supplies the constants.
*/
package rtc_pkg;

  // ========================================================================
  // Types
  typedef logic [7:0] bcd_t;
  typedef logic [1:0] chan_t;

endpackage

/* File: bcd_field.sv */
/*
  One BCD time field: counts from a low to a high bound on an increment
  enable, can be loaded, and flags when it is at its high bound.
  Assumes one clock and a synchronous active high reset.
*/
`timescale 1ns/1ns
`include "rtc_defs.svh"

module bcd_field #(
  parameter rtc_pkg::bcd_t RESET_VAL = `RESET_BYTE
) (
  input  wire logic          core_clk,
  input  wire logic          rst,
  input  wire logic          inc,
  input  wire logic          load,
  input  wire rtc_pkg::bcd_t load_val,
  input  wire rtc_pkg::bcd_t min_val,
  input  wire rtc_pkg::bcd_t max_val,
  output rtc_pkg::bcd_t      value_q,
  output logic               at_max
);

  // ========================================================================
  // Counter
  assign at_max = (value_q >= max_val);

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      value_q <= RESET_VAL;
    end
    else if (load)
    begin
      value_q <= load_val;
    end
    else if (inc)
    begin
      if (at_max)
      begin
        value_q <= min_val;
      end
      else if (value_q[3:0] == `BCD_NINE)
      begin
        value_q <= {value_q[7:4] + 4'h1, 4'h0};
      end
      else
      begin
        value_q <= {value_q[7:4], value_q[3:0] + 4'h1};
      end
    end
  end

endmodule

/* File: rtc_user_copy_timestamp.sv */
/*
  User copies of the clock registers with time-stamp freezing on tamper
  and power-down, fed from internally running BCD counters.
  Assumes a byte register port decoded from the serial bus: reg_sel is
  high for a whole bus session, reg_wr and reg_rd are one-cycle pulses.
  Tamper, power-fail and battery inputs are asynchronous pins.
*/
//
// Overview of operation
// [RL1] Armed tamper input sets its flag and freezes user time registers.
// [RL2] Clearing a channel's arm bit clears its flag; refresh resumes only once no tamper flag is set.
// [RL3] Software keeps both arm bits zero to read the current time.
// [RL4] Later tamper events never overwrite the first captured time.
// [RL5] Power-down does not set halt_update while any arm bit is set.
// [RL6] Any write to the eight time registers zeroes the fraction register.
// [RL7] Fraction register only ever stores zero from a write.
// [RL8] Century bits sit in bits 6 and 7 of the hours register.
// [RL9] Weekday is held in bits 0 to 2 of offset 04h.
// [RL10] Day of month, month and year sit at 05h, 06h, 07h.
// [RL11] Time values are BCD digits, read and written.
// [RL12] Seconds bit 7 stops the oscillator; zero restarts it.
// [RL13] Any time register write loads the clock and resets the divider.
// [RL14] Software writes non-time bits before setting the clock.
// [RL15] Time registers read singly or in sequence; control alone at 08h.
// [RL16] Refresh suspends while a time register is being accessed.
// [RL17] Refresh suspends during battery backup.
// [RL18] Power-down after power failure sets halt_update automatically.
// [RL19] Halt or tamper zeroes fraction and holds the other time registers.
// [RL20] Internal counters keep running during a freeze.
// [RL21] Writing zero to halt_update resumes refresh.
// [RL22] Tamper flags are read-only, cleared only by clearing the arm bit.
`timescale 1ns/1ns
`include "rtc_defs.svh"

module rtc_user_copy_timestamp #(
  parameter int TICK_CYCLES = `FRAC_PERIOD_NS / `CLK_PERIOD_NS
) (
  input  wire logic           core_clk,
  input  wire logic           rst,
  input  wire logic           reg_sel,
  input  wire rtc_pkg::bcd_t  reg_addr,
  input  wire logic           reg_wr,
  input  wire rtc_pkg::bcd_t  reg_wdata,
  input  wire logic           reg_rd,
  input  wire rtc_pkg::chan_t tamper_in,
  input  wire logic           power_fail,
  input  wire logic           battery_mode,
  output rtc_pkg::bcd_t       reg_rdata_q,
  output logic                reg_rvalid_q,
  output rtc_pkg::chan_t      tamper_flag_q,
  output logic                halt_update_q,
  output logic                osc_run_q
);

  // ========================================================================
  // Pin synchronisers
  rtc_pkg::chan_t tamper_m_q;
  rtc_pkg::chan_t tamper_s_q;
  logic           pf_m_q;
  logic           pf_s_q;
  logic           pf_old_q;
  logic           bat_m_q;
  logic           bat_s_q;

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      tamper_m_q <= 2'h0;
      tamper_s_q <= 2'h0;
      pf_m_q     <= 1'b0;
      pf_s_q     <= 1'b0;
      pf_old_q   <= 1'b0;
      bat_m_q    <= 1'b0;
      bat_s_q    <= 1'b0;
    end
    else
    begin
      tamper_m_q <= tamper_in;
      tamper_s_q <= tamper_m_q;
      pf_m_q     <= power_fail;
      pf_s_q     <= pf_m_q;
      pf_old_q   <= pf_s_q;
      bat_m_q    <= battery_mode;
      bat_s_q    <= bat_m_q;
    end
  end

  // ========================================================================
  // Register port decode
  rtc_pkg::bcd_t  user_q [0:7];
  rtc_pkg::bcd_t  ctrl_q;
  rtc_pkg::chan_t arm_q;
  logic           time_addr;
  logic           wr_time;
  logic           pd_event;
  logic           tamper_hit;
  logic           suspend;
  logic           load_q;

  assign time_addr  = (reg_addr <= `ADDR_YEAR);
  assign wr_time    = reg_wr && time_addr;
  assign pd_event   = pf_s_q && !pf_old_q;
  assign tamper_hit = |(tamper_s_q & arm_q);
  assign suspend    = (reg_sel && time_addr) || bat_s_q || halt_update_q
                      || (|tamper_flag_q); // RL16 RL17 RL1 RL4

  // ========================================================================
  // Arm bits and tamper flags
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      arm_q <= 2'h0;
    end
    else if (reg_wr && reg_addr == `ADDR_TAMPER1)
    begin
      arm_q[0] <= reg_wdata[`BIT_ARM];
    end
    else if (reg_wr && reg_addr == `ADDR_TAMPER2)
    begin
      arm_q[1] <= reg_wdata[`BIT_ARM];
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      tamper_flag_q <= 2'h0;
    end
    else
    begin
      // Clear wins; clear follows the arm bit only
      tamper_flag_q <= (tamper_flag_q & arm_q) | (tamper_s_q & arm_q); // RL1 RL2 RL22
    end
  end

  // ========================================================================
  // Halt update
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      halt_update_q <= 1'b0;
    end
    else if (pd_event && arm_q == 2'h0)
    begin
      halt_update_q <= 1'b1; // RL18 RL5
    end
    else if (reg_wr && reg_addr == `ADDR_HALT)
    begin
      halt_update_q <= reg_wdata[`BIT_HALT]; // RL21
    end
  end

  // ========================================================================
  // Divider and internal counters
  logic [16:0]   div_q;
  logic          tick;
  rtc_pkg::bcd_t int_val [0:7];
  logic [7:0]    wrap;
  logic [7:0]    inc;
  logic [1:0]    cent_q;
  rtc_pkg::bcd_t days_max;

  function automatic rtc_pkg::bcd_t month_days(input rtc_pkg::bcd_t mon,
                                              input rtc_pkg::bcd_t yr);
    logic leap;
    leap = yr[4] ? (yr[3:0] == 4'h2 || yr[3:0] == 4'h6)
                 : (yr[3:0] == 4'h0 || yr[3:0] == 4'h4 || yr[3:0] == 4'h8);
    if (mon == `MONTH_FEB)
      month_days = leap ? `DAYS_29 : `DAYS_28;
    else if (mon == `MONTH_APR || mon == `MONTH_JUN || mon == `MONTH_SEP
             || mon == `MONTH_NOV)
      month_days = `DAYS_30;
    else
      month_days = `DAYS_31;
  endfunction

  assign days_max = month_days(int_val[6], int_val[7]);
  assign tick     = osc_run_q && (div_q == 17'(TICK_CYCLES - 1));

  always_ff @(posedge core_clk)
  begin
    if (rst || load_q || tick)
    begin
      div_q <= 17'h0; // RL13
    end
    else if (osc_run_q)
    begin
      div_q <= div_q + 17'h1; // RL12 RL20
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      osc_run_q <= 1'b1;
    end
    else
    begin
      osc_run_q <= !user_q[1][`BIT_OSC_STOP]; // RL12
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      load_q <= 1'b0;
    end
    else
    begin
      load_q <= wr_time; // RL13
    end
  end

  assign inc[0] = tick;
  genvar gi;
  for (gi = 1; gi < 8; gi++)
  begin : g_chain
    // Day of month carries from the hours, beside the weekday
    assign inc[gi] = (gi == 5) ? (inc[3] && wrap[3]) : (inc[gi-1] && wrap[gi-1]);
  end

  localparam rtc_pkg::bcd_t MINS [0:7] = '{`BCD_ZERO, `BCD_ZERO, `BCD_ZERO,
    `BCD_ZERO, `BCD_ONE, `BCD_ONE, `BCD_ONE, `BCD_ZERO};
  localparam rtc_pkg::bcd_t MASKS [0:7] = '{`BCD_ZERO, `MASK_SECONDS,
    `MASK_MINUTES, `MASK_HOURS, `MASK_WEEKDAY, `MASK_DAY, `MASK_MONTH, `MASK_YEAR};

  for (gi = 0; gi < 8; gi++)
  begin : g_field
    rtc_pkg::bcd_t top;
    assign top = (gi == 0) ? `MAX_FRAC : (gi == 1 || gi == 2) ? `MAX_SIXTY :
                 (gi == 3) ? `MAX_HOURS : (gi == 4) ? `MAX_WEEKDAY :
                 (gi == 5) ? days_max : (gi == 6) ? `MAX_MONTH : `MAX_YEAR;
    bcd_field #(
      .RESET_VAL (MINS[gi])
    ) u_field (
      .core_clk (core_clk),
      .rst      (rst),
      .inc      (inc[gi]),
      .load     (load_q), // RL13 RL11
      .load_val (user_q[gi] & MASKS[gi]),
      .min_val  (MINS[gi]),
      .max_val  (top),
      .value_q  (int_val[gi]),
      .at_max   (wrap[gi])
    );
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      cent_q <= 2'h0;
    end
    else if (load_q)
    begin
      cent_q <= user_q[3][`CENTURY_MSB:`CENTURY_LSB]; // RL8
    end
    else if (inc[7] && wrap[7])
    begin
      cent_q <= cent_q + 2'h1;
    end
  end

  // ========================================================================
  // User copies: writes, refresh and freeze
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      for (int i = 0; i < 8; i++)
        user_q[i] <= MINS[i];
    end
    else if (wr_time)
    begin
      user_q[reg_addr[2:0]] <= reg_wdata; // RL11 RL9 RL10
      user_q[0]             <= `BCD_ZERO; // RL6 RL7
    end
    else if (halt_update_q || (|tamper_flag_q) || tamper_hit)
    begin
      user_q[0] <= `BCD_ZERO; // RL19 RL1
    end
    else if (!suspend)
    begin
      user_q[0] <= int_val[0];
      for (int i = 1; i < 8; i++)
        user_q[i] <= (user_q[i] & ~MASKS[i]) | (int_val[i] & MASKS[i]); // RL2 RL21
      user_q[3][`CENTURY_MSB:`CENTURY_LSB] <= cent_q; // RL8
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      ctrl_q <= `RESET_BYTE;
    end
    else if (reg_wr && reg_addr == `ADDR_CONTROL)
    begin
      ctrl_q <= reg_wdata; // RL15
    end
  end

  // ========================================================================
  // Read path
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      reg_rdata_q  <= `RESET_BYTE;
      reg_rvalid_q <= 1'b0;
    end
    else
    begin
      reg_rvalid_q <= reg_rd;
      if (reg_rd)
      begin
        case (reg_addr)
          `ADDR_CONTROL: reg_rdata_q <= ctrl_q; // RL15
          `ADDR_HALT:    reg_rdata_q <= {1'b0, halt_update_q, 6'h00};
          `ADDR_FLAGS:   reg_rdata_q <= {6'h00, tamper_flag_q[0], tamper_flag_q[1]}; // RL22
          `ADDR_TAMPER1: reg_rdata_q <= {arm_q[0], 7'h00};
          `ADDR_TAMPER2: reg_rdata_q <= {arm_q[1], 7'h00};
          default:       reg_rdata_q <= time_addr ? user_q[reg_addr[2:0]] : `RESET_BYTE; // RL15
        endcase
      end
    end
  end

  // ========================================================================
  // Assertions
  a_flag_needs_arm: assert property (@(posedge core_clk) disable iff (rst) // RL1
    $rose(tamper_flag_q[0]) |-> $past(arm_q[0]) && $past(tamper_s_q[0]))
    else $error("tamper flag set without arm and event");
  a_disarm_clears: assert property (@(posedge core_clk) disable iff (rst) // RL2
    !arm_q[1] |=> !tamper_flag_q[1])
    else $error("tamper flag survives a cleared arm bit");
  a_first_event_held: assert property (@(posedge core_clk) disable iff (rst) // RL4
    (|tamper_flag_q) && !wr_time ##1 !$past(wr_time) |-> $stable(user_q[1]))
    else $error("frozen seconds changed during tamper freeze");
  a_arm_blocks_halt: assert property (@(posedge core_clk) disable iff (rst) // RL5
    pd_event && arm_q != 2'h0 && !halt_update_q && !reg_wr |=> !halt_update_q)
    else $error("halt set on power-down while armed");
  a_halt_on_pd: assert property (@(posedge core_clk) disable iff (rst) // RL18
    pd_event && arm_q == 2'h0 |=> halt_update_q)
    else $error("power-down did not set halt");
  a_write_zeros_frac: assert property (@(posedge core_clk) disable iff (rst) // RL6
    wr_time |=> user_q[0] == `BCD_ZERO)
    else $error("fraction not zero after time write");
  a_halt_frac_zero: assert property (@(posedge core_clk) disable iff (rst) // RL19
    halt_update_q ##1 halt_update_q |-> user_q[0] == `BCD_ZERO)
    else $error("fraction not zero while halted");
  a_access_stable: assert property (@(posedge core_clk) disable iff (rst) // RL16
    (reg_sel && time_addr && !reg_wr && !load_q) [*2] |-> $stable(user_q[2]))
    else $error("minutes changed during time access");
  a_load_after_write: assert property (@(posedge core_clk) disable iff (rst) // RL13
    wr_time && reg_addr == `ADDR_MINUTES |=> ##1
      int_val[2] == (user_q[2] & `MASK_MINUTES) && div_q == 17'h0)
    else $error("write did not load counters and reset divider");
  a_read_answer: assert property (@(posedge core_clk) disable iff (rst) // RL15
    reg_rd && reg_addr == `ADDR_CONTROL |=> reg_rvalid_q && reg_rdata_q == ctrl_q)
    else $error("control register read wrong");
  c_tamper_freeze: cover property (@(posedge core_clk) disable iff (rst)
    $rose(tamper_flag_q[0]) ##1 (user_q[0] == `BCD_ZERO));
  c_pd_halt: cover property (@(posedge core_clk) disable iff (rst)
    $rose(halt_update_q) ##1 (user_q[0] == `BCD_ZERO));
  c_time_write: cover property (@(posedge core_clk) disable iff (rst)
    wr_time ##1 load_q);

endmodule

/* File: host_model.sv */
/*
  Host model: drives the decoded register port of the user time register
  block, one byte access per task call, changing signals on falling edges.
  Assumes the same core_clk as the block and that sessions end with stop.
*/
`timescale 1ns/1ns

module host_model (
  input  wire logic     core_clk,
  output logic          reg_sel,
  output rtc_pkg::bcd_t reg_addr,
  output logic          reg_wr,
  output rtc_pkg::bcd_t reg_wdata,
  output logic          reg_rd
);
  // ========================================================================
  // Idle levels
  initial
  begin
    reg_sel   = 1'b0;
    reg_addr  = 8'hFF;
    reg_wr    = 1'b0;
    reg_wdata = 8'h00;
    reg_rd    = 1'b0;
  end

  // ========================================================================
  // Byte write, session stays open
  task automatic wr(input rtc_pkg::bcd_t a, input rtc_pkg::bcd_t d);
    @(negedge core_clk);
    reg_sel   = 1'b1;
    reg_addr  = a;
    reg_wdata = d;
    reg_wr    = 1'b1;
    @(negedge core_clk);
    reg_wr    = 1'b0;
    reg_wdata = ~d;
  endtask

  // ========================================================================
  // Byte read, session stays open
  task automatic rd(input rtc_pkg::bcd_t a);
    @(negedge core_clk);
    reg_sel  = 1'b1;
    reg_addr = a;
    reg_rd   = 1'b1;
    @(negedge core_clk);
    reg_rd   = 1'b0;
  endtask

  // ========================================================================
  // End of session
  task automatic stop();
    @(negedge core_clk);
    reg_sel  = 1'b0;
    reg_addr = 8'hFF;
  endtask
endmodule

/* File: tb_top.sv */
/*
  Self-checking bench for the user time register block: a host model makes
  the accesses, read results are checked against a queue of expectations.
  Assumes TICK_CYCLES of 10, so one second of time is 1000 cycles.
*/
`timescale 1ns/1ns

module tb_top;
  logic           core_clk;
  logic           rst;
  logic           reg_sel;
  rtc_pkg::bcd_t  reg_addr;
  logic           reg_wr;
  rtc_pkg::bcd_t  reg_wdata;
  logic           reg_rd;
  rtc_pkg::chan_t tamper_in;
  logic           power_fail;
  logic           battery_mode;
  rtc_pkg::bcd_t  reg_rdata_q;
  logic           reg_rvalid_q;
  rtc_pkg::chan_t tamper_flag_q;
  logic           halt_update_q;
  logic           osc_run_q;
  int             num_errors = 0;
  int             n_tests = 0;
  int             s;
  rtc_pkg::bcd_t  exp_q[$];
  rtc_pkg::bcd_t  t[8];
  rtc_pkg::bcd_t  ctl;
  rtc_pkg::bcd_t  ra[13] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07,
                             8'h08, 8'h0C, 8'h0F, 8'h14, 8'h15, 8'h20};
  rtc_pkg::bcd_t  rv[13] = '{8'h00, 8'h00, 8'h00, 8'h01, 8'h01, 8'h01, 8'h00,
                             8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};

  rtc_user_copy_timestamp #(.TICK_CYCLES(10)) u_dut (
    .core_clk(core_clk), .rst(rst), .reg_sel(reg_sel), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd),
    .tamper_in(tamper_in), .power_fail(power_fail),
    .battery_mode(battery_mode), .reg_rdata_q(reg_rdata_q),
    .reg_rvalid_q(reg_rvalid_q), .tamper_flag_q(tamper_flag_q),
    .halt_update_q(halt_update_q), .osc_run_q(osc_run_q));

  host_model u_host (
    .core_clk(core_clk), .reg_sel(reg_sel), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd));

  // ========================================================================
  // Clock and helpers
  always #50 core_clk = ~core_clk;

  function automatic rtc_pkg::bcd_t bcd(input int n);
    return rtc_pkg::bcd_t'((n / 10) * 16 + n % 10);
  endfunction

  task automatic check(input rtc_pkg::bcd_t seen, input rtc_pkg::bcd_t exp);
    n_tests++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("[FAIL] %0t got %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic rd(input rtc_pkg::bcd_t a, input rtc_pkg::bcd_t e);
    exp_q.push_back(e);
    u_host.rd(a);
  endtask

  task automatic wait_cyc(input int n);
    repeat (n) @(negedge core_clk);
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // ========================================================================
  // Read result monitor
  always @(negedge core_clk)
  begin
    if (reg_rvalid_q === 1'b1)
    begin
      if (exp_q.size() == 0)
      begin
        num_errors++;
        $display("[FAIL] %0t unexpected read data", $time);
      end
      else
        check(reg_rdata_q, exp_q.pop_front());
    end
  end

  // ========================================================================
  // Watchdog
  initial
  begin
    #2000000;
    num_errors++;
    $display("[FAIL] %0t watchdog expired", $time);
    conclude();
  end

  // ========================================================================
  // Tests
  initial
  begin
    core_clk     = 1'b0;
    rst          = 1'b1;
    tamper_in    = 2'b00;
    power_fail   = 1'b0;
    battery_mode = 1'b0;
    wait_cyc(8);
    rst = 1'b0;
    void'($urandom(11644));
    foreach (ra[i]) rd(ra[i], rv[i]);
    u_host.stop();
    check(8'(osc_run_q), 8'h01);
    check(8'(halt_update_q), 8'h00);
    $display("reset test done");

    s    = $urandom_range(57);
    t[1] = bcd(s);
    t[2] = bcd($urandom_range(59));
    t[3] = bcd($urandom_range(23)) | rtc_pkg::bcd_t'($urandom_range(3) << 6);
    t[4] = bcd($urandom_range(7, 1));
    t[5] = bcd($urandom_range(28, 1));
    t[6] = bcd($urandom_range(12, 1));
    t[7] = bcd($urandom_range(99));
    ctl  = rtc_pkg::bcd_t'($urandom);
    u_host.wr(8'h01, t[1] | 8'h80);
    wait_cyc(3);
    check(8'(osc_run_q), 8'h00);
    // Non-time bits land together with the time
    for (int i = 1; i < 8; i++) u_host.wr(8'(i), t[i]);
    wait_cyc(3);
    check(8'(osc_run_q), 8'h01);
    rd(8'h00, 8'h00);
    u_host.wr(8'h00, 8'h55);
    rd(8'h00, 8'h00);
    for (int i = 1; i < 8; i++) rd(8'(i), t[i]);
    u_host.wr(8'h08, ctl);
    rd(8'h08, ctl);
    $display("register test done");

    u_host.wr(8'h01, bcd(s));
    wait_cyc(1500);
    rd(8'h01, bcd(s));
    u_host.stop();
    wait_cyc(20);
    rd(8'h01, bcd(s + 1));
    u_host.wr(8'h01, bcd(s));
    u_host.stop();
    battery_mode = 1'b1;
    wait_cyc(1500);
    rd(8'h01, bcd(s));
    u_host.stop();
    battery_mode = 1'b0;
    wait_cyc(20);
    rd(8'h01, bcd(s + 1));
    $display("suspend test done");

    u_host.wr(8'h01, bcd(s));
    u_host.stop();
    wait_cyc(300);
    power_fail = 1'b1;
    wait_cyc(6);
    check(8'(halt_update_q), 8'h01);
    wait_cyc(1200);
    rd(8'h00, 8'h00);
    rd(8'h01, bcd(s));
    u_host.wr(8'h0C, 8'h00);
    u_host.stop();
    check(8'(halt_update_q), 8'h00);
    rd(8'h01, bcd(s + 1));
    u_host.stop();
    power_fail = 1'b0;
    $display("power-down test done");

    u_host.wr(8'h01, bcd(s));
    u_host.wr(8'h14, 8'h80);
    u_host.wr(8'h15, 8'h80);
    rd(8'h14, 8'h80);
    u_host.stop();
    wait_cyc(100);
    tamper_in = 2'b01;
    wait_cyc(5);
    check(8'(tamper_flag_q), 8'h01);
    wait_cyc(1100);
    tamper_in = 2'b11;
    wait_cyc(5);
    check(8'(tamper_flag_q), 8'h03);
    rd(8'h00, 8'h00);
    rd(8'h01, bcd(s));
    u_host.wr(8'h0F, 8'h00);
    rd(8'h0F, 8'h03);
    power_fail = 1'b1;
    wait_cyc(6);
    check(8'(halt_update_q), 8'h00);
    tamper_in = 2'b00;
    u_host.wr(8'h14, 8'h00);
    wait_cyc(1);
    check(8'(tamper_flag_q), 8'h02);
    rd(8'h0F, 8'h01);
    rd(8'h01, bcd(s));
    // Both arms cleared before the current time is read
    u_host.wr(8'h15, 8'h00);
    u_host.stop();
    rd(8'h01, bcd(s + 1));
    u_host.stop();
    power_fail = 1'b0;
    $display("tamper test done");

    wait_cyc(5);
    check(8'(exp_q.size()), 8'h00);
    conclude();
  end
endmodule
